// ==== rtl/t3tmr_pkg.sv ====
`default_nettype none
package t3tmr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam int EV_W = 5;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CTRL1 = 16'hA100;
    localparam logic [15:0] IDX_CTRL2 = 16'hA101;
    localparam logic [15:0] IDX_CNT_L = 16'hA102;
    localparam logic [15:0] IDX_CNT_M = 16'hA103;
    localparam logic [15:0] IDX_CNT_H = 16'hA104;
    localparam logic [15:0] IDX_RLD_L = 16'hA105;
    localparam logic [15:0] IDX_CMP_L = 16'hA018;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hA110;
    localparam logic [15:0] IDX_IRQ_CLR = 16'hA111;
    localparam logic [15:0] IDX_IRQ_EN = 16'hA112;

    // ------------------------------------------------------------
    // Field positions of the first control register
    // ------------------------------------------------------------
    localparam int FLAG_LSB = 3;
    localparam int B_WRITE_GATE = 2;

    // ------------------------------------------------------------
    // Field positions of the second control register
    // ------------------------------------------------------------
    localparam int B_CMP2_EN = 7;
    localparam int B_CMP1_EN = 6;
    localparam int B_WRAP24_EN = 5;
    localparam int B_WRAP16_EN = 4;
    localparam int B_WRAP8_EN = 3;
    localparam int B_INIT_SEL = 2;
    localparam int B_RUN = 1;
    localparam int B_AUTO = 0;

    // ------------------------------------------------------------
    // Event positions, same order as the flag field
    // ------------------------------------------------------------
    localparam int EV_WRAP8 = 0;
    localparam int EV_WRAP16 = 1;
    localparam int EV_WRAP24 = 2;
    localparam int EV_CMP1 = 3;
    localparam int EV_CMP2 = 4;

    // ------------------------------------------------------------
    // Reset values and tick selection
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_RST = 24'h000000;
    localparam logic [EV_W-1:0] EV_RST = 5'h00;
    localparam logic [1:0] TICK_DIV8 = 2'h0;
    localparam logic [1:0] TICK_DIV4 = 2'h1;
    localparam logic [1:0] TICK_DIV2 = 2'h2;
    localparam logic [1:0] TICK_DIV1 = 2'h3;
    localparam logic [2:0] PRESC_RST = 3'h0;

endpackage
`default_nettype wire

// ==== rtl/t3tmr_prescale.sv ====
`timescale 1ns/1ps
`default_nettype none
module t3tmr_prescale
    import t3tmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] tick_source_select,
    output logic tick
);

    typedef struct packed
    {
        logic [2:0] div;
        logic tick;
    } t3tmr_presc_type;

    t3tmr_presc_type st;
    t3tmr_presc_type next_st;

    // ------------------------------------------------------------
    // Free-running divider of the core clock
    // ------------------------------------------------------------
    always_comb
    begin
        next_st.div = st.div + 3'h1;
        case (tick_source_select)
            TICK_DIV8: next_st.tick = (st.div == 3'h7);
            TICK_DIV4: next_st.tick = (st.div[1:0] == 2'h3);
            TICK_DIV2: next_st.tick = st.div[0];
            TICK_DIV1: next_st.tick = 1'b1;
            default: next_st.tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '{div: PRESC_RST, tick: 1'b0};
        else
            st <= next_st;
    end

    assign tick = st.tick;

endmodule
`default_nettype wire

// ==== rtl/t3tmr_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module t3tmr_irq
    import t3tmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [EV_W-1:0] events,
    input wire logic clr_we,
    input wire logic en_we,
    input wire logic [EV_W-1:0] wdata,
    output logic [EV_W-1:0] status,
    output logic [EV_W-1:0] enable,
    output logic irq
);

    typedef struct packed
    {
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] enable;
    } t3tmr_irq_type;

    t3tmr_irq_type st;
    t3tmr_irq_type next_st;

    // ------------------------------------------------------------
    // Sticky status; a new event wins over a clear
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        if (clr_we)
            next_st.status = st.status & ~wdata;
        next_st.status = next_st.status | events;
        if (en_we)
            next_st.enable = wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '{status: EV_RST, enable: EV_RST};
        else
            st <= next_st;
    end

    assign status = st.status;
    assign enable = st.enable;
    assign irq = |(st.status & st.enable);

endmodule
`default_nettype wire

// ==== rtl/t3tmr_timer3.sv ====
`timescale 1ns/1ps
`default_nettype none
module t3tmr_timer3
    import t3tmr_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] cmp1;
        logic [EV_W-1:0] flags;
        logic [1:0] tick_sel;
        logic [7:0] ctrl2;
        logic [31:0] prdata;
        logic pslverr;
    } t3tmr_state_type;

    t3tmr_state_type st;
    t3tmr_state_type next_st;

    logic tick;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic access_wr;
    logic setup;
    logic step;
    logic at_top;
    logic init_wr;
    logic [CNT_W-1:0] count_step;
    logic [7:0] rd_byte;
    logic mapped;
    logic irq_clr_we;
    logic irq_en_we;
    logic ctrl1_wr;
    logic ctrl2_wr;
    logic [2:0] rld_wr;
    logic [2:0] cmp_wr;
    logic wrap8_hit;
    logic wrap16_hit;
    logic wrap24_hit;
    logic cmp1_hit;
    logic cmp2_hit;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction

    function automatic logic [7:0] pick(input logic [CNT_W-1:0] v,
                                        input int b);
        pick = v[8*b +: 8];
    endfunction

    // ------------------------------------------------------------
    // Register selects, decoded once and shared by reads and the control, count and interrupt writes
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        SEL_NONE = 4'h0,
        SEL_CTRL1 = 4'h1,
        SEL_CTRL2 = 4'h2,
        SEL_CNT_L = 4'h3,
        SEL_CNT_M = 4'h4,
        SEL_CNT_H = 4'h5,
        SEL_RLD_L = 4'h6,
        SEL_RLD_M = 4'h7,
        SEL_RLD_H = 4'h8,
        SEL_CMP_L = 4'h9,
        SEL_CMP_M = 4'hA,
        SEL_CMP_H = 4'hB,
        SEL_STAT = 4'hC,
        SEL_CLR = 4'hD,
        SEL_EN = 4'hE
    } t3tmr_sel_type;

    t3tmr_sel_type sel;

    function automatic t3tmr_sel_type decode(input logic [ADDR_W-1:0] a);
        decode = SEL_NONE;
        if (hit(a, IDX_CTRL1))
            decode = SEL_CTRL1;
        else if (hit(a, IDX_CTRL2))
            decode = SEL_CTRL2;
        else if (hit(a, IDX_CNT_L))
            decode = SEL_CNT_L;
        else if (hit(a, IDX_CNT_M))
            decode = SEL_CNT_M;
        else if (hit(a, IDX_CNT_H))
            decode = SEL_CNT_H;
        else if (hit(a, IDX_RLD_L))
            decode = SEL_RLD_L;
        else if (hit(a, IDX_RLD_L + 16'h0001))
            decode = SEL_RLD_M;
        else if (hit(a, IDX_RLD_L + 16'h0002))
            decode = SEL_RLD_H;
        else if (hit(a, IDX_CMP_L))
            decode = SEL_CMP_L;
        else if (hit(a, IDX_CMP_L + 16'h0001))
            decode = SEL_CMP_M;
        else if (hit(a, IDX_CMP_L + 16'h0002))
            decode = SEL_CMP_H;
        else if (hit(a, IDX_IRQ_STAT))
            decode = SEL_STAT;
        else if (hit(a, IDX_IRQ_CLR))
            decode = SEL_CLR;
        else if (hit(a, IDX_IRQ_EN))
            decode = SEL_EN;
    endfunction

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    t3tmr_prescale u_prescale
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick_source_select(st.tick_sel),
        .tick(tick)
    );

    t3tmr_irq u_irq
    (
        .pclk(pclk),
        .presetn(presetn),
        .events(ev),
        .clr_we(irq_clr_we),
        .en_we(irq_en_we),
        .wdata(pwdata[EV_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Bus phases; zero wait states
    // ------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign pready = psel & penable;
    assign sel = decode(paddr);
    assign irq_clr_we = access_wr & (sel == SEL_CLR);
    assign irq_en_we = access_wr & (sel == SEL_EN);
    assign init_wr = access_wr & (sel == SEL_CNT_L);
    assign ctrl1_wr = access_wr & (sel == SEL_CTRL1);
    assign ctrl2_wr = access_wr & (sel == SEL_CTRL2);

    // ------------------------------------------------------------
    // Byte strobes of the reload and compare-1 values
    // ------------------------------------------------------------
    for (genvar b = 0; b < 3; b++)
    begin
        assign rld_wr[b] = access_wr & hit(paddr, IDX_RLD_L + 16'(b));
        assign cmp_wr[b] = access_wr & hit(paddr, IDX_CMP_L + 16'(b));
    end

    // ------------------------------------------------------------
    // Counter step
    // ------------------------------------------------------------
    assign step = st.ctrl2[B_RUN] & tick;
    assign at_top = &st.count;

    always_comb
    begin
        count_step = st.count + CNT_W'(1);
        if (at_top && st.ctrl2[B_AUTO])
            count_step = st.reload;
    end

    // ------------------------------------------------------------
    // Events; a step replaced by an initialising write raises none
    // ------------------------------------------------------------
    assign wrap8_hit = &st.count[7:0];
    assign wrap16_hit = &st.count[15:0];
    assign wrap24_hit = at_top;
    // Compares look at the value being stepped to, so a match fires once
    assign cmp1_hit = (count_step == st.cmp1);
    assign cmp2_hit = (count_step == st.reload) & ~st.ctrl2[B_AUTO];

    always_comb
    begin
        ev = EV_RST;
        if (step && !init_wr)
        begin
            ev[EV_WRAP8] = wrap8_hit & st.ctrl2[B_WRAP8_EN];
            ev[EV_WRAP16] = wrap16_hit & st.ctrl2[B_WRAP16_EN];
            ev[EV_WRAP24] = wrap24_hit & st.ctrl2[B_WRAP24_EN];
            ev[EV_CMP1] = cmp1_hit & st.ctrl2[B_CMP1_EN];
            ev[EV_CMP2] = cmp2_hit & st.ctrl2[B_CMP2_EN];
        end
    end

    // ------------------------------------------------------------
    // Read data and map check
    // ------------------------------------------------------------
    always_comb
    begin
        rd_byte = 8'h00;
        mapped = 1'b1;
        case (sel)
            SEL_CTRL1:
                rd_byte = {st.flags, 1'b0, st.tick_sel};
            SEL_CTRL2:
                rd_byte = st.ctrl2;
            SEL_CNT_L:
                rd_byte = pick(st.count, 0);
            SEL_CNT_M:
                rd_byte = pick(st.count, 1);
            SEL_CNT_H:
                rd_byte = pick(st.count, 2);
            SEL_RLD_L:
                rd_byte = pick(st.reload, 0);
            SEL_RLD_M:
                rd_byte = pick(st.reload, 1);
            SEL_RLD_H:
                rd_byte = pick(st.reload, 2);
            SEL_CMP_L:
                rd_byte = pick(st.cmp1, 0);
            SEL_CMP_M:
                rd_byte = pick(st.cmp1, 1);
            SEL_CMP_H:
                rd_byte = pick(st.cmp1, 2);
            SEL_STAT:
                rd_byte = {3'h0, irq_status};
            SEL_EN:
                rd_byte = {3'h0, irq_enable};
            SEL_CLR:
                rd_byte = 8'h00;
            default:
                mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;

        // Read data is captured in the setup cycle so that it leaves
        // a flip-flop when the access phase completes
        if (setup)
        begin
            next_st.pslverr = ~mapped;
            if (!pwrite)
                next_st.prdata = {24'h000000, rd_byte};
        end

        if (step)
            next_st.count = count_step;

        if (init_wr)
        begin
            if (st.ctrl2[B_INIT_SEL])
                next_st.count = st.reload;
            else
                next_st.count = COUNT_RST;
        end

        if (ctrl1_wr)
        begin
            // Zero clears a flag, one keeps it
            next_st.flags = st.flags
                & pwdata[7:FLAG_LSB];
            if (!pwdata[B_WRITE_GATE])
                next_st.tick_sel = pwdata[1:0];
        end

        // Hardware only ever sets; applied after the clear so it wins
        next_st.flags = next_st.flags | ev;

        if (ctrl2_wr)
            next_st.ctrl2 = pwdata[7:0];

        for (int b = 0; b < 3; b++)
        begin
            if (rld_wr[b])
                next_st.reload[8*b +: 8] = pwdata[7:0];
            if (cmp_wr[b])
                next_st.cmp1[8*b +: 8] = pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.count <= COUNT_RST;
            st.reload <= COUNT_RST;
            st.cmp1 <= COUNT_RST;
            st.flags <= CTRL1_RST[7:FLAG_LSB];
            st.tick_sel <= CTRL1_RST[1:0];
            st.ctrl2 <= CTRL2_RST;
            st.prdata <= 32'h00000000;
            st.pslverr <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = st.prdata;
    assign pslverr = st.pslverr & psel & penable;

endmodule
`default_nettype wire

// ==== testbench/t3tmr_timer3_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module t3tmr_timer3_assertions
    import t3tmr_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [15:0] i;
        i = 16'(a >> 2);
        return (a[1:0] == 2'h0) &&
            ((i >= IDX_CTRL1 && i <= IDX_RLD_L + 16'h0002) ||
             (i >= IDX_CMP_L && i <= IDX_CMP_L + 16'h0002) ||
             (i >= IDX_IRQ_STAT && i <= IDX_IRQ_EN));
    endfunction

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    property p_ready;
        pready == (psel && penable);
    endproperty
    a_ready: assert property (p_ready) else $error("pready wrong");
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray pslverr");
    property p_err_map;
        psel && penable |-> pslverr == !mapped(paddr);
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr map");
    property p_rd_upper;
        prdata[31:8] == 24'h000000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("prdata upper");
    // Read data is captured at the setup edge only
    property p_rd_hold;
        $changed(prdata) |-> $past(psel && !penable && !pwrite);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
    property p_clr_read;
        psel && penable && !pwrite && paddr == {IDX_IRQ_CLR, 2'h0}
            |-> prdata == 32'h00000000;
    endproperty
    a_clr_read: assert property (p_clr_read) else $error("clear reg read");
    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    property p_irq_fall;
        $fell(irq) |-> $past(psel && penable && pwrite);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
    property p_irq_rst;
        $rose(presetn) |-> !irq ##1 !irq;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq at reset");

    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_wr: cover property (psel && penable && pwrite);
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import t3tmr_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] a;
    int errors = 0;
    int comparisons = 0;

    always #20 pclk = ~pclk;

    t3tmr_timer3 #(.ADDR_W(18)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [15:0] idx,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_flag(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h000000, d});
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 32'h00000000);
        check($sformatf("reg %h", idx), {24'h000000, e}, rd);
    endtask
    task automatic irq_is(input logic e);
        @(negedge pclk);
        check_flag("irq", e, irq);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_gate;
        rdc(IDX_CTRL1, 8'h00);
        rdc(IDX_CTRL2, 8'h00);
        rdc(IDX_IRQ_EN, 8'h00);
        rdc(IDX_IRQ_CLR, 8'h00);
        irq_is(1'b0);
        apb(1'b0, 16'h0000, 32'h00000000);
        check_flag("pslverr", 1'b1, er);
        wr(IDX_CTRL1, 8'hFB);
        rdc(IDX_CTRL1, 8'h03);
        wr(IDX_CTRL1, 8'h04);
        rdc(IDX_CTRL1, 8'h03);
        wr(IDX_CTRL1, 8'h01);
        rdc(IDX_CTRL1, 8'h01);
    endtask
    // Window of 64 edges holds an exact number of ticks at any phase
    task automatic t_rate;
        wr(IDX_CTRL2, 8'h02);
        for (int c = 0; c < 4; c++)
        begin
            wr(IDX_CTRL1, 8'(c));
            apb(1'b0, IDX_CNT_L, 32'h00000000);
            a = rd[7:0];
            repeat (61) @(posedge pclk);
            apb(1'b0, IDX_CNT_L, 32'h00000000);
            check("ticks", 32'(64 >> (3 - c)), 32'(8'(rd[7:0] - a)));
        end
        wr(IDX_CTRL2, 8'h00);
    endtask
    task automatic t_wrap;
        wr(IDX_CTRL1, 8'h03);
        wr(IDX_IRQ_CLR, 8'h1F);
        wr(IDX_RLD_L, 8'hFE);
        wr(IDX_RLD_L + 16'h0001, 8'hFF);
        wr(IDX_RLD_L + 16'h0002, 8'hFF);
        wr(IDX_CTRL2, 8'h3C);
        wr(IDX_CNT_L, 8'h00);
        rdc(IDX_CNT_H, 8'hFF);
        wr(IDX_CTRL2, 8'h3E);
        repeat (4) @(posedge pclk);
        wr(IDX_CTRL2, 8'h3C);
        rdc(IDX_CNT_H, 8'h00);
        rdc(IDX_CTRL1, 8'h3B);
        rdc(IDX_IRQ_STAT, 8'h07);
        irq_is(1'b0);
        wr(IDX_IRQ_EN, 8'h1F);
        irq_is(1'b1);
        wr(IDX_IRQ_CLR, 8'h07);
        irq_is(1'b0);
        wr(IDX_CTRL1, 8'h03);
        rdc(IDX_CTRL1, 8'h03);
    endtask
    task automatic t_auto;
        wr(IDX_RLD_L, 8'hF0);
        wr(IDX_CTRL2, 8'h25);
        wr(IDX_CNT_L, 8'h00);
        wr(IDX_CTRL2, 8'h27);
        repeat (40) @(posedge pclk);
        wr(IDX_CTRL2, 8'h25);
        rdc(IDX_CNT_M, 8'hFF);
        rdc(IDX_CNT_H, 8'hFF);
        rdc(IDX_CTRL1, 8'h23);
    endtask
    task automatic t_cmp;
        logic [7:0] m;
        wr(IDX_CTRL1, 8'h03);
        wr(IDX_CMP_L, 8'h10);
        wr(IDX_CMP_L + 16'h0001, 8'h00);
        wr(IDX_CMP_L + 16'h0002, 8'h00);
        wr(IDX_RLD_L, 8'h20);
        wr(IDX_RLD_L + 16'h0001, 8'h00);
        wr(IDX_RLD_L + 16'h0002, 8'h00);
        for (int au = 0; au < 2; au++)
        begin
            m = au ? 8'h43 : 8'hC3;
            wr(IDX_IRQ_CLR, 8'h1F);
            wr(IDX_CTRL1, 8'h03);
            wr(IDX_CTRL2, 8'hC0 | 8'(au));
            wr(IDX_CNT_L, 8'h00);
            wr(IDX_CTRL2, 8'hC2 | 8'(au));
            repeat (50) @(posedge pclk);
            wr(IDX_CTRL2, 8'hC0 | 8'(au));
            rdc(IDX_CTRL1, m);
            rdc(IDX_IRQ_STAT, {3'h0, m[7:6], 3'h0});
        end
        apb(1'b0, IDX_CNT_L, 32'h00000000);
        a = rd[7:0];
        repeat (20) @(posedge pclk);
        rdc(IDX_CNT_L, a);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_gate();
        t_rate();
        t_wrap();
        t_auto();
        t_cmp();
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
endmodule

bind t3tmr_timer3 t3tmr_timer3_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
